// file: rtl/cpp_pair.v
// Coupled PWM pair without dead-time: APB registers, shared counter,
// buffered compare values, external trigger and two output pins.
// Assumes inputs synchronous to clock_i and an APB3 master.
//
// The APB slave port and the register offsets were chosen for this implementation.
`include "cpp_defines.vh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Run set: status and counting both next tick
// - Count equals duty1 buffer: flag1 cleared
// - Count equals duty2 buffer: flag2 cleared
// - Count equals period2 buffer: flag2 set
// - Period1 match: flag1 set, counter zeroed
// - Period1 match reloads all four buffers
// - Run cleared: one more count, status drops
// - Restart resumes from retained count
// - One-shot: setting run restarts counting
// - Counter byte write zeroes counter, sets flag1
// - Writes while stopped load buffers directly
// - Clock, interrupt point, polarities from controls
// - External pin starts, stops or clears pair
// - Output1 period is period1 plus one
// - Output1 active time is duty1 plus one
// - Output2 delay1 is duty2 plus one
// - Output2 delay2 is period2 plus one
// - First interrupt late by one clock at most
// - Active when coupled and no dead-time
module cpp_pair #(
	parameter CNT_W = 16,
	parameter DIV_W = 16
) (
	// Clock and reset
	input wire clock_i,
	input wire srst_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	// External clock and trigger pins
	input wire pwm_ext_clk_i,
	input wire trig_a_i,
	input wire trig_b_i,
	// Outputs
	output wire pwm_first_o,
	output wire pwm_second_o,
	output wire pair_event_o
);

//////////////////////////////////////////////////////////////////////////////
// Registers
reg [7:0] first_control_zero_ff;
reg [7:0] first_clock_select_control_ff;
reg [7:0] first_trigger_control_ff;
reg [7:0] second_control_zero_ff;
reg pair_run_bit_ff;
reg pair_running_status_ff;
reg oneshot_select_ff;
reg coupling_enable_ff;
reg deadtime_enable_ff;
reg [CNT_W-1:0] first_period_ff;
reg [CNT_W-1:0] first_duty_ff;
reg [CNT_W-1:0] second_period_ff;
reg [CNT_W-1:0] second_duty_ff;
reg [CNT_W-1:0] first_period_buffer_ff;
reg [CNT_W-1:0] first_duty_buffer_ff;
reg [CNT_W-1:0] period_buffer_ff;
reg [CNT_W-1:0] second_duty_buffer_ff;
reg [CNT_W-1:0] count_ff;
reg counting_ff;
reg first_output_flag_ff;
reg second_output_flag_ff;
reg pwm_first_ff;
reg pwm_second_ff;
reg event_ff;
reg [DIV_W-1:0] div_ff;
reg ext_clk_ff;
reg trig_prev_ff;
reg [31:0] prdata_ff;

//////////////////////////////////////////////////////////////////////////////
// APB decode
wire apb_wr = psel_i & penable_i & pwrite_i;
wire apb_rd = psel_i & penable_i & ~pwrite_i;
reg addr_hit;
always @* begin
	case (paddr_i)
		`CPP_OFF_CTRL0, `CPP_OFF_CLKSEL, `CPP_OFF_RUN, `CPP_OFF_TRIG,
		`CPP_OFF_CTRL7, `CPP_OFF_CNT_LO, `CPP_OFF_CNT_HI, `CPP_OFF_PER1,
		`CPP_OFF_DUTY1, `CPP_OFF_PER2, `CPP_OFF_DUTY2: addr_hit = 1'b1;
		default: addr_hit = 1'b0;
	endcase
end
assign pready_o = 1'b1;
// Unmapped access flags an error; writes there are dropped
assign pslverr_o = psel_i & penable_i & ~addr_hit;
assign prdata_o = prdata_ff;

wire wr_ctrl0 = apb_wr & (paddr_i == `CPP_OFF_CTRL0);
wire wr_clksel = apb_wr & (paddr_i == `CPP_OFF_CLKSEL);
wire wr_run = apb_wr & (paddr_i == `CPP_OFF_RUN);
wire wr_trig = apb_wr & (paddr_i == `CPP_OFF_TRIG);
wire wr_ctrl7 = apb_wr & (paddr_i == `CPP_OFF_CTRL7);
wire wr_cnt = apb_wr & ((paddr_i == `CPP_OFF_CNT_LO) |
	(paddr_i == `CPP_OFF_CNT_HI));
wire wr_per1 = apb_wr & (paddr_i == `CPP_OFF_PER1);
wire wr_duty1 = apb_wr & (paddr_i == `CPP_OFF_DUTY1);
wire wr_per2 = apb_wr & (paddr_i == `CPP_OFF_PER2);
wire wr_duty2 = apb_wr & (paddr_i == `CPP_OFF_DUTY2);

//////////////////////////////////////////////////////////////////////////////
// PWM clock: one-cycle tick at each falling edge of the divided or external clock, tick every clock for sources 2 and 3
wire [1:0] clk_src = first_control_zero_ff[`CPP_C0_SRC_LSB+1:`CPP_C0_SRC_LSB];
wire [3:0] div_sel = first_clock_select_control_ff[3:0];
wire [DIV_W-1:0] div_nxt = div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
// Divided clock bit div_sel falls when it goes 1 to 0
wire div_fall = div_ff[div_sel] & ~div_nxt[div_sel];
wire ext_fall = ext_clk_ff & ~pwm_ext_clk_i;
reg tick;
always @* begin
	case (clk_src)
		`CPP_SRC_DIV: tick = div_fall;
		`CPP_SRC_EXT: tick = ext_fall;
		// Sources 2 and 3 tick every clock, mainly for fast tests
		default: tick = 1'b1;
	endcase
end

always @(posedge clock_i) begin
	if (srst_i) begin
		div_ff <= {DIV_W{1'b0}};
		ext_clk_ff <= 1'b0;
	end else begin
		div_ff <= div_nxt;
		ext_clk_ff <= pwm_ext_clk_i;
	end
end

//////////////////////////////////////////////////////////////////////////////
// External trigger
wire [1:0] trig_fn = first_trigger_control_ff[`CPP_TRG_FN_LSB+1:
	`CPP_TRG_FN_LSB];
wire [1:0] trig_edge = first_trigger_control_ff[`CPP_TRG_EDGE_LSB+1:
	`CPP_TRG_EDGE_LSB];
wire trig_pin = first_trigger_control_ff[`CPP_TRG_PIN] ? trig_b_i : trig_a_i;
reg trig_hit;
always @* begin
	case (trig_edge)
		`CPP_EDGE_RISE: trig_hit = trig_pin & ~trig_prev_ff;
		`CPP_EDGE_FALL: trig_hit = ~trig_pin & trig_prev_ff;
		`CPP_EDGE_BOTH: trig_hit = trig_pin ^ trig_prev_ff;
		// Level mode acts every cycle while the pin stays high
		default: trig_hit = trig_pin;
	endcase
end
wire trg_start = trig_hit & (trig_fn == `CPP_FN_START);
wire trg_stop = trig_hit & (trig_fn == `CPP_FN_STOP);
wire trg_clear = trig_hit & (trig_fn == `CPP_FN_CLEAR);

always @(posedge clock_i) begin
	if (srst_i)
		trig_prev_ff <= 1'b0;
	else
		trig_prev_ff <= trig_pin;
end

//////////////////////////////////////////////////////////////////////////////
// Counting core
// Other mode combinations are outside this block, so it holds still
wire mode_ok = coupling_enable_ff & ~deadtime_enable_ff;
// Both status and counting are set on the first tick, so the first
// step falls on the second tick
wire step = tick & mode_ok & pair_running_status_ff & counting_ff;
wire per_match = step & (count_ff == first_period_buffer_ff);
wire stopped = ~pair_running_status_ff;
wire clear_cnt = wr_cnt | trg_clear;

// Run bit: software or trigger set beats the one-shot self clear
always @(posedge clock_i) begin
	if (srst_i) begin
		pair_run_bit_ff <= 1'b0;
	end else if (wr_run) begin
		pair_run_bit_ff <= pwdata_i[`CPP_RUN_BIT];
	end else if (trg_start) begin
		pair_run_bit_ff <= 1'b1;
	end else if (trg_stop) begin
		pair_run_bit_ff <= 1'b0;
	end else if (per_match & oneshot_select_ff) begin
		pair_run_bit_ff <= 1'b0;
	end
end

// Status and counting both rise on the first tick after run is set
always @(posedge clock_i) begin
	if (srst_i) begin
		pair_running_status_ff <= 1'b0;
		counting_ff <= 1'b0;
	end else if (per_match & oneshot_select_ff & ~wr_run) begin
		pair_running_status_ff <= 1'b0;
		counting_ff <= 1'b0;
	end else if (tick & mode_ok) begin
		if (pair_run_bit_ff) begin
			pair_running_status_ff <= 1'b1;
			counting_ff <= 1'b1;
		end else if (pair_running_status_ff) begin
			// Last step happens on this tick, then halt
			pair_running_status_ff <= 1'b0;
			counting_ff <= 1'b0;
		end
	end
end

// Counter keeps its value across stop and restart
always @(posedge clock_i) begin
	if (srst_i)
		count_ff <= `CPP_RST_CNT;
	else if (clear_cnt)
		count_ff <= `CPP_RST_CNT;
	else if (per_match)
		count_ff <= `CPP_RST_CNT;
	else if (step)
		count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
end

// Output flags; period match outranks duty match
always @(posedge clock_i) begin
	if (srst_i) begin
		first_output_flag_ff <= 1'b1;
		second_output_flag_ff <= 1'b1;
	end else begin
		if (clear_cnt | per_match)
			first_output_flag_ff <= 1'b1;
		else if (step & (count_ff == first_duty_buffer_ff))
			first_output_flag_ff <= 1'b0;
		if (step & (count_ff == period_buffer_ff))
			second_output_flag_ff <= 1'b1;
		else if (step & (count_ff == second_duty_buffer_ff))
			second_output_flag_ff <= 1'b0;
	end
end

//////////////////////////////////////////////////////////////////////////////
// Setting registers and buffers
always @(posedge clock_i) begin
	if (srst_i) begin
		first_period_ff <= `CPP_RST_PER;
		first_duty_ff <= `CPP_RST_DUTY;
		second_period_ff <= `CPP_RST_PER;
		second_duty_ff <= `CPP_RST_DUTY;
	end else begin
		if (wr_per1)
			first_period_ff <= pwdata_i[CNT_W-1:0];
		if (wr_duty1)
			first_duty_ff <= pwdata_i[CNT_W-1:0];
		if (wr_per2)
			second_period_ff <= pwdata_i[CNT_W-1:0];
		if (wr_duty2)
			second_duty_ff <= pwdata_i[CNT_W-1:0];
	end
end

// A write while stopped reaches the buffer at once.
// A reload at period match wins over a same-cycle direct write;
// the register still keeps the new value for the next reload.
always @(posedge clock_i) begin
	if (srst_i) begin
		first_period_buffer_ff <= `CPP_RST_PER;
		first_duty_buffer_ff <= `CPP_RST_DUTY;
		period_buffer_ff <= `CPP_RST_PER;
		second_duty_buffer_ff <= `CPP_RST_DUTY;
	end else if (per_match) begin
		first_period_buffer_ff <= first_period_ff;
		first_duty_buffer_ff <= first_duty_ff;
		period_buffer_ff <= second_period_ff;
		second_duty_buffer_ff <= second_duty_ff;
	end else if (stopped) begin
		if (wr_per1)
			first_period_buffer_ff <= pwdata_i[CNT_W-1:0];
		if (wr_duty1)
			first_duty_buffer_ff <= pwdata_i[CNT_W-1:0];
		if (wr_per2)
			period_buffer_ff <= pwdata_i[CNT_W-1:0];
		if (wr_duty2)
			second_duty_buffer_ff <= pwdata_i[CNT_W-1:0];
	end
end

// Control registers
always @(posedge clock_i) begin
	if (srst_i) begin
		first_control_zero_ff <= 8'h00;
		first_clock_select_control_ff <= 8'h00;
		first_trigger_control_ff <= 8'h00;
		second_control_zero_ff <= 8'h00;
		oneshot_select_ff <= 1'b0;
		coupling_enable_ff <= 1'b0;
		deadtime_enable_ff <= 1'b0;
	end else begin
		if (wr_ctrl0)
			first_control_zero_ff <= pwdata_i[7:0];
		if (wr_clksel)
			first_clock_select_control_ff <= pwdata_i[7:0];
		if (wr_trig)
			first_trigger_control_ff <= pwdata_i[7:0];
		if (wr_ctrl7)
			second_control_zero_ff <= pwdata_i[7:0];
		if (wr_run) begin
			oneshot_select_ff <= pwdata_i[`CPP_RUN_ONESHOT];
			coupling_enable_ff <= pwdata_i[`CPP_RUN_COUPLE];
			deadtime_enable_ff <= pwdata_i[`CPP_RUN_DTIME];
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// Pins and event
// Event point: period match, or first duty match when selected
wire duty_event = step & (count_ff == first_duty_buffer_ff);
wire ev_now = first_control_zero_ff[`CPP_C0_IPT] ? duty_event : per_match;
always @(posedge clock_i) begin
	if (srst_i) begin
		pwm_first_ff <= 1'b0;
		pwm_second_ff <= 1'b0;
		event_ff <= 1'b0;
	end else begin
		pwm_first_ff <= first_output_flag_ff ^
			first_control_zero_ff[`CPP_C0_POL];
		pwm_second_ff <= second_output_flag_ff ^
			second_control_zero_ff[`CPP_C7_POL];
		event_ff <= ev_now;
	end
end
assign pwm_first_o = pwm_first_ff;
assign pwm_second_o = pwm_second_ff;
assign pair_event_o = event_ff;

//////////////////////////////////////////////////////////////////////////////
// Read data, registered in the setup cycle
reg [31:0] rd_mux;
always @* begin
	case (paddr_i)
		`CPP_OFF_CTRL0: rd_mux = {24'h000000, first_control_zero_ff};
		`CPP_OFF_CLKSEL: rd_mux = {24'h000000, first_clock_select_control_ff};
		`CPP_OFF_RUN: rd_mux = {27'h0000000, deadtime_enable_ff,
			coupling_enable_ff, oneshot_select_ff,
			pair_running_status_ff, pair_run_bit_ff};
		`CPP_OFF_TRIG: rd_mux = {24'h000000, first_trigger_control_ff};
		`CPP_OFF_CTRL7: rd_mux = {24'h000000, second_control_zero_ff};
		`CPP_OFF_CNT_LO: rd_mux = {24'h000000, count_ff[7:0]};
		`CPP_OFF_CNT_HI: rd_mux = {24'h000000, count_ff[15:8]};
		`CPP_OFF_PER1: rd_mux = {16'h0000, first_period_ff};
		`CPP_OFF_DUTY1: rd_mux = {16'h0000, first_duty_ff};
		`CPP_OFF_PER2: rd_mux = {16'h0000, second_period_ff};
		`CPP_OFF_DUTY2: rd_mux = {16'h0000, second_duty_ff};
		default: rd_mux = 32'h00000000;
	endcase
end
// Data is loaded in the setup cycle so it is stable when pready samples.
// Reads have no side effects, so loading early is harmless.
always @(posedge clock_i) begin
	if (srst_i)
		prdata_ff <= 32'h00000000;
	else if (psel_i & ~penable_i & ~pwrite_i)
		prdata_ff <= rd_mux;
	else if (apb_rd)
		prdata_ff <= prdata_ff;
end

endmodule // cpp_pair

// file: rtl/cpp_defines.vh
// Constants for the coupled PWM pair: register offsets, fields, resets.
// Assumes a 32-bit APB slave decoding byte addresses in its low bits.
`ifndef CPP_DEFINES_VH
`define CPP_DEFINES_VH

// Register byte offsets
`define CPP_OFF_CTRL0 8'h00
`define CPP_OFF_CLKSEL 8'h04
`define CPP_OFF_RUN 8'h08
`define CPP_OFF_TRIG 8'h0c
`define CPP_OFF_CTRL7 8'h10
`define CPP_OFF_CNT_LO 8'h14
`define CPP_OFF_CNT_HI 8'h18
`define CPP_OFF_PER1 8'h1c
`define CPP_OFF_DUTY1 8'h20
`define CPP_OFF_PER2 8'h24
`define CPP_OFF_DUTY2 8'h28

// first_control_zero fields
`define CPP_C0_SRC_LSB 0
`define CPP_C0_POL 2
`define CPP_C0_IPT 3
// first_run_control fields
`define CPP_RUN_BIT 0
`define CPP_RUN_STAT 1
`define CPP_RUN_ONESHOT 2
`define CPP_RUN_COUPLE 3
`define CPP_RUN_DTIME 4
// first_trigger_control fields
`define CPP_TRG_FN_LSB 0
`define CPP_TRG_EDGE_LSB 2
`define CPP_TRG_PIN 4
// second_control_zero field
`define CPP_C7_POL 0

// Trigger functions
`define CPP_FN_NONE 2'h0
`define CPP_FN_START 2'h1
`define CPP_FN_STOP 2'h2
`define CPP_FN_CLEAR 2'h3
// Trigger edge or level
`define CPP_EDGE_RISE 2'h0
`define CPP_EDGE_FALL 2'h1
`define CPP_EDGE_BOTH 2'h2
`define CPP_EDGE_HIGH 2'h3

// PWM clock sources
`define CPP_SRC_DIV 2'h0
`define CPP_SRC_EXT 2'h1

// Reset values
`define CPP_RST_PER 16'hffff
`define CPP_RST_DUTY 16'h0000
`define CPP_RST_CNT 16'h0000

`endif

// file: sim/cpp_pair_asserts.sv
// Port checker for the coupled PWM pair.
// Assumes it is bound to cpp_pair and the offsets of cpp_defines.vh.
`include "cpp_defines.vh"
module cpp_pair_asserts (
	// Clock and reset
	input wire clock_i,
	input wire srst_i,
	// APB
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	// Pins
	input wire pwm_first_o,
	input wire pwm_second_o,
	input wire pair_event_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);
	wire acc = psel_i && penable_i;
	wire unm = (paddr_i > `CPP_OFF_DUTY2) || (paddr_i[1:0] != 2'h0);
	logic [15:0] per1_ff, duty1_ff;
	logic cpl_ff;
	logic [1:0] idle_ff;
	//////////////////////////////////////////////////////////////////////
	// Shadows of written settings; reads return registers, not buffers
	always @(posedge clock_i) begin
		if (srst_i) begin
			per1_ff <= `CPP_RST_PER;
			duty1_ff <= `CPP_RST_DUTY;
			cpl_ff <= 1'b0;
			idle_ff <= 2'h0;
		end else begin
			if (acc && pwrite_i && paddr_i == `CPP_OFF_PER1)
				per1_ff <= pwdata_i[15:0];
			if (acc && pwrite_i && paddr_i == `CPP_OFF_DUTY1)
				duty1_ff <= pwdata_i[15:0];
			if (acc && pwrite_i && paddr_i == `CPP_OFF_RUN)
				cpl_ff <= pwdata_i[`CPP_RUN_COUPLE];
			if (cpl_ff || (acc && paddr_i == `CPP_OFF_CTRL7))
				idle_ff <= 2'h0;
			else if (idle_ff != 2'h3)
				idle_ff <= idle_ff + 2'h1;
		end
	end
	//////////////////////////////////////////////////////////////////////
	a_ready_always: assert property (psel_i |-> pready_o)
		else $error("pready low during a transfer");
	a_err_unmapped: assert property (acc && unm |-> pslverr_o)
		else $error("no error on unmapped access");
	a_err_mapped: assert property (acc && !unm |-> !pslverr_o)
		else $error("error on mapped access");
	a_rd_unmapped_zero: assert property (acc && unm && !pwrite_i
		|-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_per_readback: assert property (acc && !pwrite_i
		&& paddr_i == `CPP_OFF_PER1 |-> prdata_o[15:0] == per1_ff)
		else $error("period readback wrong");
	a_duty_readback: assert property (acc && !pwrite_i
		&& paddr_i == `CPP_OFF_DUTY1 |-> prdata_o[15:0] == duty1_ff)
		else $error("duty readback wrong");
	a_second_idle: assert property (idle_ff == 2'h3
		|-> $stable(pwm_second_o))
		else $error("second pin moved while uncoupled");
	a_event_single: assert property (pair_event_o |=> !pair_event_o)
		else $error("event longer than one cycle");
	cover property (pair_event_o);
	cover property (acc && pwrite_i && paddr_i == `CPP_OFF_CNT_HI);
	cover property (acc && unm);
endmodule // cpp_pair_asserts

// file: sim/cpp_pair_tb_top.sv
// Self-checking bench for the coupled PWM pair over APB.
// Assumes zero-wait APB and a tick every clock with clock source 2.
`include "cpp_defines.vh"
module cpp_pair_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, rd;
	logic pwm_ext_clk_i = 0, trig_a_i = 0, trig_b_i = 0, err;
	logic [15:0] cnt, c0;
	wire [31:0] prdata_o;
	wire pready_o, pslverr_o, pwm_first_o, pwm_second_o, pair_event_o;
	int num_errors = 0, checked = 0, seed = 32'h26c7, p1, d1, p2, d2;
	cpp_pair dut (.clock_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.pwm_ext_clk_i, .trig_a_i, .trig_b_i, .pwm_first_o,
		.pwm_second_o, .pair_event_o);
	initial forever #2.5 clock_i = ~clock_i;
	// Slow external PWM clock: falling edge every 4 cycles
	always begin
		repeat (2) @(posedge clock_i);
		pwm_ext_clk_i <= ~pwm_ext_clk_i;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1;
		@(posedge clock_i);
		while (pready_o !== 1'b1 && n < 50) begin
			n++;
			@(posedge clock_i);
		end
		if (n >= 50)
			num_errors++;
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	// Counter read while stopped, so the two bytes agree
	task automatic rdcnt();
		apb(0, `CPP_OFF_CNT_LO, 0);
		cnt[7:0] = rd[7:0];
		apb(0, `CPP_OFF_CNT_HI, 0);
		cnt[15:8] = rd[7:0];
	endtask
	// Edge offsets of both pins from a rise of the first pin
	task automatic measure();
		int k, n, t1f, t1r, t2f, t2r, ev;
		logic a1, a2;
		n = 0;
		ev = 0;
		t1f = 0;
		t1r = 0;
		t2f = 0;
		t2r = 0;
		while (pwm_first_o !== 1'b0 && n < 300) begin
			n++;
			@(posedge clock_i);
		end
		while (pwm_first_o !== 1'b1 && n < 600) begin
			n++;
			@(posedge clock_i);
		end
		for (k = 1; k <= p1 + 1; k++) begin
			a1 = pwm_first_o;
			a2 = pwm_second_o;
			@(posedge clock_i);
			if ({a1, pwm_first_o} === 2'b10) t1f = k;
			if ({a1, pwm_first_o} === 2'b01) t1r = k;
			if ({a2, pwm_second_o} === 2'b10) t2f = k;
			if ({a2, pwm_second_o} === 2'b01) t2r = k;
			if (pair_event_o === 1'b1) ev++;
		end
		chk(ev, 1);
		chk(t1f, d1 + 1);
		chk(t1r, p1 + 1);
		chk(t2f, d2 + 1);
		chk(t2r, p2 + 1);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clock_i);
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clock_i);
		srst_i <= 0;
		apb(0, `CPP_OFF_PER1, 0);
		chk(rd[15:0], `CPP_RST_PER);
		apb(0, `CPP_OFF_DUTY2, 0);
		chk(rd[15:0], `CPP_RST_DUTY);
		apb(1, 8'h3c, 32'h5a);
		chk(err, 1);
		apb(0, 8'h3c, 0);
		chk(rd, 0);
		apb(1, `CPP_OFF_CTRL0, 32'h6);
		apb(1, `CPP_OFF_CTRL7, 32'h1);
		repeat (2) @(posedge clock_i);
		chk({pwm_first_o, pwm_second_o}, 0);
		apb(1, `CPP_OFF_CTRL0, 32'h2);
		apb(1, `CPP_OFF_CTRL7, 32'h0);
		for (int i = 0; i < 3; i++) begin
			p1 = 4 + {$random(seed)} % 16;
			d1 = {$random(seed)} % p1;
			p2 = 1 + {$random(seed)} % p1;
			d2 = {$random(seed)} % p2;
			apb(1, `CPP_OFF_PER1, p1);
			apb(1, `CPP_OFF_DUTY1, d1);
			apb(1, `CPP_OFF_PER2, p2);
			apb(1, `CPP_OFF_DUTY2, d2);
			if (i == 0) begin
				apb(1, `CPP_OFF_CNT_HI, 32'h7);
				rdcnt();
				chk(cnt, 0);
				chk(pwm_first_o, 1);
				apb(1, `CPP_OFF_RUN, 32'h9);
				apb(0, `CPP_OFF_RUN, 0);
				chk(rd[1], 1);
			end
			measure();
		end
		apb(1, `CPP_OFF_PER1, 32'h400);
		repeat (200) @(posedge clock_i);
		apb(1, `CPP_OFF_RUN, 32'h8);
		repeat (4) @(posedge clock_i);
		apb(0, `CPP_OFF_RUN, 0);
		chk(rd[1:0], 0);
		rdcnt();
		c0 = cnt;
		repeat (10) @(posedge clock_i);
		rdcnt();
		chk(cnt, c0);
		apb(1, `CPP_OFF_RUN, 32'h9);
		repeat (10) @(posedge clock_i);
		apb(1, `CPP_OFF_RUN, 32'h8);
		repeat (4) @(posedge clock_i);
		rdcnt();
		chk(cnt > c0 && cnt <= c0 + 20, 1);
		apb(1, `CPP_OFF_CTRL0, 32'h1);
		apb(1, `CPP_OFF_CNT_LO, 0);
		apb(1, `CPP_OFF_PER1, 32'h5);
		apb(1, `CPP_OFF_DUTY1, 32'h2);
		apb(1, `CPP_OFF_RUN, 32'hd);
		repeat (150) @(posedge clock_i);
		apb(0, `CPP_OFF_RUN, 0);
		chk(rd[2:0], 3'h4);
		rdcnt();
		chk(cnt, 0);
		apb(1, `CPP_OFF_RUN, 32'hd);
		repeat (8) @(posedge clock_i);
		apb(0, `CPP_OFF_RUN, 0);
		chk(rd[1], 1);
		repeat (150) @(posedge clock_i);
		apb(1, `CPP_OFF_CTRL0, 32'h2);
		apb(1, `CPP_OFF_RUN, 32'h8);
		apb(1, `CPP_OFF_TRIG, 32'h1);
		trig_a_i <= 1;
		repeat (3) @(posedge clock_i);
		apb(0, `CPP_OFF_RUN, 0);
		chk(rd[1], 1);
		apb(1, `CPP_OFF_TRIG, 32'h1e);
		trig_b_i <= 1;
		repeat (4) @(posedge clock_i);
		apb(0, `CPP_OFF_RUN, 0);
		chk(rd[1:0], 0);
		apb(1, `CPP_OFF_TRIG, 32'hb);
		trig_a_i <= 0;
		repeat (2) @(posedge clock_i);
		rdcnt();
		chk(cnt, 0);
		report_and_stop();
	end
endmodule // cpp_pair_tb_top

bind cpp_pair cpp_pair_asserts u_chk (.clock_i, .srst_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
	.pslverr_o, .pwm_first_o, .pwm_second_o, .pair_event_o);
